/* File: core/cfg_port_decode.sv */
// Address decoder for the index and data ports.
// Assumes the base address is stable in the cycle of the request.
`timescale 1ns/1ps
`include "cfg_port_defines.svh"

module cfg_port_decode (
  input  wire logic [15:0] addr,
  input  wire logic        aen,
  input  wire logic [15:0] base,
  output logic             hit_index,
  output logic             hit_data
);
  import cfg_port_pkg::*;

  // =====================================================================
  // Match helper, gated by AEN so DMA cycles never hit
  function automatic logic match_addr(input logic [15:0] a, input logic [15:0] b, input logic en);
    match_addr = en && (a == b);
  endfunction

  wire logic [15:0] data_addr = base + `DATA_PORT_OFFS;

  // Index port at the base, data port one above
  assign hit_index = match_addr(addr, base, !aen);
  assign hit_data  = match_addr(addr, data_addr, !aen);

endmodule

/* File: core/cfg_port_defines.svh */
// Constants of the configuration-port access logic: keys, indexes, addresses, timing.
// Assumes a 100 MHz device clock; included by its bare name.
`ifndef CFG_PORT_DEFINES_SVH
`define CFG_PORT_DEFINES_SVH

// =====================================================================
// Keys written to the configuration port
`define KEY_ENTER        8'h55
`define KEY_EXIT         8'hAA

// =====================================================================
// Port base addresses selected by the strap
`define BASE_STRAP_LOW   16'h03F0
`define BASE_STRAP_HIGH  16'h0370
`define DATA_PORT_OFFS   16'h0001

// =====================================================================
// Global register indexes handled locally
`define IDX_CFG_CTRL     8'h02
`define IDX_LD_NUM       8'h07
`define IDX_BASE_LOW     8'h26
`define IDX_BASE_HIGH    8'h27
`define CFG_CTRL_SOFT_BIT 0

// =====================================================================
// Reset values
`define LD_NUM_RST       8'h00
`define INDEX_RST        8'h00

// =====================================================================
// Timing
`define CLK_MHZ          100
`define POR_BLANK_US     500
`define POR_BLANK_CYCLES (`POR_BLANK_US * `CLK_MHZ)

`endif

/* File: core/cfg_port_pkg.sv */
// Types shared by the configuration-port access logic and its address decoder.
// Assumes the defines header supplies all numeric constants.
package cfg_port_pkg;

  // ===================================================================
  // Host bus request, sampled synchronously to CLK
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;    // One-cycle write strobe
    logic        rd;    // One-cycle read strobe
    logic        aen;   // High during DMA cycles
  } isa_req_t;

  // ===================================================================
  // Access forwarded to the logical-device register files
  typedef struct packed {
    logic [7:0] ld_num;
    logic [7:0] index;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cfg_access_t;

  // ===================================================================
  // Access state
  typedef enum logic {ST_RUN, ST_CFG} access_state_t;

endpackage

/* File: core/config_port_access_fsm.sv */
// Configuration-port access logic: key-driven run/configuration states, index and data ports.
// Assumes host strobes are single-cycle pulses synchronous to CLK; SYS_RST is the supply POR.
`timescale 1ns/1ps
`include "cfg_port_defines.svh"

module config_port_access_fsm #(
  parameter int POR_BLANK = `POR_BLANK_CYCLES
) (
  input  wire logic                      CLK,
  input  wire logic                      SYS_RST,
  input  wire logic                      BUS_RST,
  input  wire logic                      BASE_SELECT_STRAP,
  input  wire cfg_port_pkg::isa_req_t    ISA_REQ,
  input  wire logic [7:0]                LD_RDATA,
  output cfg_port_pkg::cfg_access_t      CFG_ACC,
  output logic [7:0]                     RD_DATA,
  output logic                           RD_VALID,
  output logic                           CFG_MODE,
  output logic                           DEV_HARD_RST,
  output logic                           SOFT_RST
);
  import cfg_port_pkg::*;

  // =====================================================================
  // State
  access_state_t mode_q, mode_d;
  logic [15:0]   base_q;
  logic [7:0]    index_q, ld_num_q;
  logic          bus_rst_q;
  logic          init_done_q;
  logic [15:0]   blank_q;
  logic          rd_pend_q, rd_local_q;
  logic [7:0]    rd_lval_q;
  cfg_access_t   acc_q;
  logic          cfg_mode_q, hard_q, soft_q;
  logic [7:0]    rd_data_q;
  logic          rd_valid_q;

  // =====================================================================
  // Address decode
  logic hit_index, hit_data;

  cfg_port_decode u_decode (
    .addr      (ISA_REQ.addr),
    .aen       (ISA_REQ.aen),
    .base      (base_q),
    .hit_index (hit_index),
    .hit_data  (hit_data)
  );

  // =====================================================================
  // Access qualification
  // Blanking and bus reset gate everything, so no stray write lands mid-reset
  wire logic blank     = (blank_q != 16'h0000);
  wire logic live      = !blank && !BUS_RST && init_done_q;
  wire logic in_cfg    = (mode_q == ST_CFG);
  wire logic wr_index  = live && ISA_REQ.wr && hit_index;
  wire logic wr_data   = live && ISA_REQ.wr && hit_data && in_cfg;
  wire logic rd_index  = live && ISA_REQ.rd && hit_index && in_cfg;
  wire logic rd_data   = live && ISA_REQ.rd && hit_data && in_cfg;
  wire logic key_enter = wr_index && !in_cfg && (ISA_REQ.wdata == `KEY_ENTER);
  wire logic key_exit  = wr_index && in_cfg && (ISA_REQ.wdata == `KEY_EXIT);
  wire logic idx_write = wr_index && in_cfg && !key_exit;
  wire logic bus_fall  = bus_rst_q && !BUS_RST;

  // Local global registers versus those forwarded to the device files
  wire logic is_ctrl   = (index_q == `IDX_CFG_CTRL);
  wire logic is_ldn    = (index_q == `IDX_LD_NUM);
  wire logic is_blo    = (index_q == `IDX_BASE_LOW);
  wire logic is_bhi    = (index_q == `IDX_BASE_HIGH);
  wire logic is_local  = is_ctrl || is_ldn || is_blo || is_bhi;
  wire logic soft_hit  = wr_data && is_ctrl && ISA_REQ.wdata[`CFG_CTRL_SOFT_BIT];
  wire logic load_base = !init_done_q || bus_fall;
  wire logic [15:0] strap_base = BASE_SELECT_STRAP ? `BASE_STRAP_HIGH : `BASE_STRAP_LOW;

  // Value of a local register; control register reads as zero
  wire logic [7:0] local_val = is_ldn ? ld_num_q :
                               is_blo ? base_q[7:0] :
                               is_bhi ? base_q[15:8] : 8'h00;

  // =====================================================================
  // Two-state key machine; run state takes only the entry key
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      ST_RUN: if (key_enter) mode_d = ST_CFG;
      ST_CFG: if (key_exit)  mode_d = ST_RUN;
    endcase
    if (BUS_RST) mode_d = ST_RUN;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) mode_q <= ST_RUN;
    else mode_q <= mode_d;
  end

  // =====================================================================
  // Power-on blanking counter and strap capture after release
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      blank_q     <= 16'(POR_BLANK);
      init_done_q <= 1'b0;
      bus_rst_q   <= 1'b0;
    end else begin
      if (blank) blank_q <= blank_q - 16'h0001;
      init_done_q <= 1'b1;
      bus_rst_q   <= BUS_RST;
    end
  end

  // =====================================================================
  // Port base: strap at power-on or bus reset fall, then software relocation
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) base_q <= `BASE_STRAP_LOW;
    else if (load_base) base_q <= strap_base;
    else if (wr_data && is_blo) base_q[7:0] <= ISA_REQ.wdata;
    else if (wr_data && is_bhi) base_q[15:8] <= ISA_REQ.wdata;
  end

  // =====================================================================
  // Index and logical device number; both hold until rewritten or bus reset, and a soft reset also clears the device number
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      index_q  <= `INDEX_RST;
      ld_num_q <= `LD_NUM_RST;
    end else if (BUS_RST) begin
      index_q  <= `INDEX_RST;
      ld_num_q <= `LD_NUM_RST;
    end else begin
      if (idx_write) index_q <= ISA_REQ.wdata;
      if (soft_hit) ld_num_q <= `LD_NUM_RST;
      else if (wr_data && is_ldn) ld_num_q <= ISA_REQ.wdata;
    end
  end

  // =====================================================================
  // Read pipeline: stage one strobes the device file, stage two answers
  // Fixed two-cycle latency keeps local and forwarded reads alike
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_pend_q  <= 1'b0;
      rd_local_q <= 1'b0;
      rd_lval_q  <= 8'h00;
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_pend_q  <= rd_index || rd_data;
      rd_local_q <= rd_index || is_local;
      rd_lval_q  <= rd_index ? index_q : local_val;
      rd_valid_q <= rd_pend_q;
      if (rd_pend_q) rd_data_q <= rd_local_q ? rd_lval_q : LD_RDATA;
    end
  end

  // =====================================================================
  // Forwarded accesses and status outputs, all registered
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      acc_q      <= '0;
      cfg_mode_q <= 1'b0;
      hard_q     <= 1'b1;
      soft_q     <= 1'b0;
    end else begin
      acc_q.ld_num <= ld_num_q;
      acc_q.index  <= index_q;
      if (wr_data) acc_q.wdata <= ISA_REQ.wdata;
      acc_q.wr     <= wr_data && !is_local;
      acc_q.rd     <= rd_data && !is_local;
      cfg_mode_q   <= (mode_d == ST_CFG);
      hard_q       <= BUS_RST;
      soft_q       <= soft_hit;
    end
  end

  assign CFG_ACC      = acc_q;
  assign RD_DATA      = rd_data_q;
  assign RD_VALID     = rd_valid_q;
  assign CFG_MODE     = cfg_mode_q;
  assign DEV_HARD_RST = hard_q;
  assign SOFT_RST     = soft_q;

  // =====================================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_bus_reset_run;
    BUS_RST |=> !CFG_MODE && DEV_HARD_RST;
  endproperty
  a_bus_reset_run: assert property (p_bus_reset_run) else $error("Not in run state during bus reset");

  property p_strap_base;
    bus_fall |=> base_q == ($past(BASE_SELECT_STRAP) ? 16'h0370 : 16'h03F0);
  endproperty
  a_strap_base: assert property (p_strap_base) else $error("Base not taken from strap");

  property p_relocate_low;
    wr_data && is_blo && !load_base |=> base_q[7:0] == $past(ISA_REQ.wdata);
  endproperty
  a_relocate_low: assert property (p_relocate_low) else $error("Base low byte not relocated");

  property p_aen_blocks;
    ISA_REQ.aen |-> !hit_index && !hit_data;
  endproperty
  a_aen_blocks: assert property (p_aen_blocks) else $error("Decode hit during DMA cycle");

  property p_run_no_data;
    !in_cfg |=> !CFG_ACC.wr && !CFG_ACC.rd ##1 !RD_VALID;
  endproperty
  a_run_no_data: assert property (p_run_no_data) else $error("Data port active in run state");

  property p_enter_key;
    key_enter && !BUS_RST |=> CFG_MODE;
  endproperty
  a_enter_key: assert property (p_enter_key) else $error("Entry key not accepted");

  property p_exit_key;
    key_exit && !BUS_RST |=> !CFG_MODE ##1 (!CFG_MODE || $past(key_enter));
  endproperty
  a_exit_key: assert property (p_exit_key) else $error("Exit key not accepted");

  property p_forward_write;
    wr_data && !is_local |=> CFG_ACC.wr && CFG_ACC.wdata == $past(ISA_REQ.wdata)
                             && CFG_ACC.index == $past(index_q);
  endproperty
  a_forward_write: assert property (p_forward_write) else $error("Data write not forwarded");

  property p_soft_reset;
    soft_hit |=> SOFT_RST && ld_num_q == 8'h00;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("Soft reset not raised");

  property p_blank_ignore;
    blank |=> $stable(mode_q) && $stable(index_q) && !CFG_ACC.wr;
  endproperty
  a_blank_ignore: assert property (p_blank_ignore) else $error("Access taken during power-on blanking");

  property p_run_other_byte;
    wr_index && !in_cfg && ISA_REQ.wdata != 8'h55 && !BUS_RST |=> !CFG_MODE && $stable(index_q);
  endproperty
  a_run_other_byte: assert property (p_run_other_byte) else $error("Run state took a non-key byte");

  property p_ld_hold;
    !(wr_data && is_ldn) && !soft_hit && !BUS_RST |=> $stable(ld_num_q);
  endproperty
  a_ld_hold: assert property (p_ld_hold) else $error("Logical device number changed unasked");

  c_enter_exit: cover property (key_enter ##[1:20] key_exit);
  c_ld_select:  cover property (wr_data && is_ldn ##[1:10] wr_data && !is_local);
  c_fwd_read:   cover property (rd_data && !is_local ##2 RD_VALID);
  c_relocate:   cover property (wr_data && is_bhi);

endmodule

/* File: verification/config_port_access_fsm_tb.sv */
// Self-checking bench for the configuration-port access logic.
// Assumes the defines header and package are compiled first; drives on falling edges.
`timescale 1ns/1ps
`include "cfg_port_defines.svh"

module config_port_access_fsm_tb;
  import cfg_port_pkg::*;

  localparam int BLANK = 8;

  logic        clk;
  logic        sys_rst;
  logic        bus_rst;
  logic        strap;
  isa_req_t    req;
  logic [7:0]  ld_rdata;
  cfg_access_t acc;
  cfg_access_t acc_s;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        cfg_mode;
  logic        dev_hard_rst;
  logic        soft_rst;
  logic        soft_s;
  logic [7:0]  d;
  logic        v;
  int          mismatches;
  int          check_count;

  // ===================================================================
  // Design and far-side model
  config_port_access_fsm #(.POR_BLANK(BLANK)) i_dut (
    .CLK(clk), .SYS_RST(sys_rst), .BUS_RST(bus_rst), .BASE_SELECT_STRAP(strap),
    .ISA_REQ(req), .LD_RDATA(ld_rdata), .CFG_ACC(acc), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .CFG_MODE(cfg_mode), .DEV_HARD_RST(dev_hard_rst), .SOFT_RST(soft_rst)
  );
  ld_file_model i_ld (.clk(clk), .dev_hard_rst(dev_hard_rst), .acc(acc), .rdata(ld_rdata));

  // ===================================================================
  // Compare and bus tasks
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Two cycles per write so the strobe never drops and rises in one time step
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] dat, input logic dma = 1'b0);
    req = '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0, aen: dma};
    @(negedge clk);
    acc_s = acc;
    soft_s = soft_rst;
    req.wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic bus_rd(input logic [15:0] a);
    req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, aen: 1'b0};
    @(negedge clk);
    req.rd = 1'b0;
    @(negedge clk);
    v = rd_valid;
    d = rd_data;
  endtask

  // ===================================================================
  // Scenarios
  // Keys land on the second and the last blanked edge, then on the second free one
  task automatic t_power_on();
    @(negedge clk);
    bus_wr(`BASE_STRAP_LOW, `KEY_ENTER);
    chk1("mode in blanking", 1'b0, cfg_mode);
    repeat (BLANK - 4) @(negedge clk);
    bus_wr(`BASE_STRAP_LOW, `KEY_ENTER);
    chk1("mode at last blanked edge", 1'b0, cfg_mode);
    bus_wr(`BASE_STRAP_LOW, `KEY_ENTER);
    chk1("mode after blanking", 1'b1, cfg_mode);
    bus_wr(`BASE_STRAP_LOW, `KEY_EXIT);
    chk1("mode after first exit", 1'b0, cfg_mode);
    chk1("hard reset released", 1'b0, dev_hard_rst);
  endtask

  task automatic t_run_ignored();
    bus_wr(16'h03F0, 8'h12);
    bus_wr(16'h03F1, `KEY_ENTER);
    chk1("mode after stray writes", 1'b0, cfg_mode);
    bus_wr(16'h03F0, `KEY_ENTER, 1'b1);
    chk1("mode after DMA key", 1'b0, cfg_mode);
    bus_rd(16'h03F0);
    chk1("read valid in run", 1'b0, v);
  endtask

  task automatic t_walk();
    bus_wr(16'h03F0, `KEY_ENTER);
    chk1("mode after entry key", 1'b1, cfg_mode);
    bus_wr(16'h03F0, `IDX_LD_NUM);
    bus_wr(16'h03F1, 8'h08);
    chk1("ldn write kept local", 1'b0, acc_s.wr);
    bus_rd(16'h03F1);
    chk8("ldn read back", 8'h08, d);
    chk1("read valid in cfg", 1'b1, v);
    bus_wr(16'h03F0, 8'hE0);
    bus_wr(16'h03F1, 8'h02);
    chk1("data write strobe", 1'b1, acc_s.wr);
    chk8("forwarded ldn", 8'h08, acc_s.ld_num);
    chk8("forwarded index", 8'hE0, acc_s.index);
    chk8("forwarded data", 8'h02, acc_s.wdata);
    bus_rd(16'h03F1);
    chk8("forwarded read", 8'h02, d);
    chk1("forwarded read valid", 1'b1, v);
    bus_wr(16'h03F0, 8'h77, 1'b1);
    bus_rd(16'h03F0);
    chk8("index after DMA write", 8'hE0, d);
    bus_wr(16'h03F0, `KEY_ENTER);
    bus_rd(16'h03F0);
    chk8("entry key as index", `KEY_ENTER, d);
    bus_wr(16'h03F1, 8'h33);
    chk8("ldn held", 8'h08, acc_s.ld_num);
    bus_wr(16'h03F0, `KEY_EXIT);
    chk1("mode after exit key", 1'b0, cfg_mode);
    bus_rd(16'h03F1);
    chk1("data read in run", 1'b0, v);
  endtask

  task automatic t_relocate();
    bus_wr(16'h03F0, `KEY_ENTER);
    bus_wr(16'h03F0, `IDX_BASE_LOW);
    bus_wr(16'h03F1, 8'h50);
    bus_wr(16'h0350, `IDX_BASE_HIGH);
    bus_wr(16'h0351, 8'h02);
    bus_rd(16'h0250);
    chk8("index at new base", `IDX_BASE_HIGH, d);
    bus_wr(16'h0250, `KEY_EXIT);
    bus_wr(16'h03F0, `KEY_ENTER);
    chk1("old base ignored", 1'b0, cfg_mode);
    bus_wr(16'h0250, `KEY_ENTER);
    chk1("entry at new base", 1'b1, cfg_mode);
    bus_wr(16'h0250, `IDX_LD_NUM);
    bus_wr(16'h0251, 8'h05);
    bus_wr(16'h0250, `IDX_CFG_CTRL);
    bus_wr(16'h0251, 8'h00);
    chk1("no soft reset on zero", 1'b0, soft_s);
    bus_wr(16'h0251, 8'h01);
    chk1("soft reset pulse", 1'b1, soft_s);
    chk1("soft reset one cycle", 1'b0, soft_rst);
    chk1("no hard reset", 1'b0, dev_hard_rst);
    chk8("ldn after soft reset", 8'h00, acc.ld_num);
  endtask

  // Strap flips while bus reset is high; the falling edge must pick it up
  task automatic t_bus_reset();
    strap = 1'b1;
    bus_rst = 1'b1;
    @(negedge clk);
    chk1("hard reset out", 1'b1, dev_hard_rst);
    repeat (3) @(negedge clk);
    bus_rst = 1'b0;
    repeat (2) @(negedge clk);
    chk1("mode after bus reset", 1'b0, cfg_mode);
    chk8("ldn after bus reset", 8'h00, acc.ld_num);
    bus_wr(`BASE_STRAP_LOW, `KEY_ENTER);
    chk1("low base with strap high", 1'b0, cfg_mode);
    bus_wr(`BASE_STRAP_HIGH, `KEY_ENTER);
    chk1("entry at strap base", 1'b1, cfg_mode);
    bus_wr(`BASE_STRAP_HIGH + `DATA_PORT_OFFS, 8'h44);
    chk1("data port at base plus one", 1'b1, acc_s.wr);
    bus_wr(`BASE_STRAP_HIGH, `KEY_EXIT);
    chk1("exit at strap base", 1'b0, cfg_mode);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ===================================================================
  // Clock, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    sys_rst = 1'b1;
    bus_rst = 1'b0;
    strap = 1'b0;
    req = '0;
    mismatches = 0;
    check_count = 0;
    repeat (16) @(negedge clk);
    chk1("hard reset in power-on", 1'b1, dev_hard_rst);
    chk1("mode in power-on", 1'b0, cfg_mode);
    sys_rst = 1'b0;
    t_power_on();
    t_run_ignored();
    t_walk();
    t_relocate();
    t_bus_reset();
    complete_run();
  end

  // The whole sequence needs well under 300 cycles; a hang is cut at 10000
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
endmodule

/* File: verification/ld_file_model.sv */
// Behavioural logical-device register files that answer forwarded configuration accesses.
// Assumes the read answer is wanted in the same cycle as the forwarded read strobe.
`timescale 1ns/1ps

module ld_file_model
  import cfg_port_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    dev_hard_rst,
  input  wire cfg_port_pkg::cfg_access_t acc,
  output logic [7:0]                   rdata
);
  // ===================================================================
  // Storage
  logic [7:0]  mem_q [0:4095];
  logic [7:0]  noise_q = 8'h5A;
  logic [11:0] slot;

  // Only the low nibble of the device number is kept, enough for this chip
  assign slot = {acc.ld_num[3:0], acc.index};

  // Hard reset clears every activate byte so the devices come up switched off
  always_ff @(posedge clk) begin
    noise_q <= noise_q + 8'h3B;
    if (dev_hard_rst) begin
      for (int i = 0; i < 16; i++) begin
        mem_q[{i[3:0], 8'h30}] <= 8'h00;
      end
    end else if (acc.wr) begin
      mem_q[slot] <= acc.wdata;
    end
  end

  // Outside the strobe the bus carries a changing pattern, never the last answer
  assign rdata = acc.rd ? mem_q[slot] : noise_q;
endmodule
